// File: timer2_pkg.sv
// package: constants and control bundle for the 16-bit reload/capture timer
package timer2_pkg;

  localparam int unsigned SYSTEM_CLOCK_DIVIDE = 12;
  localparam int unsigned RTC_DIVIDE = 8;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
  localparam logic [15:0] WORD_ALL_ONES = 16'hffff;
  localparam logic [1:0] SRC_SYSTEM_CLOCK_DIV12 = 2'h0;
  localparam logic [1:0] SRC_RTC_DIV8 = 2'h1;
  localparam logic [1:0] SRC_RESERVED = 2'h2;
  localparam logic [1:0] SRC_COMPARATOR = 2'h3;
  localparam int unsigned SRC_MSB_POS = 1;
  localparam int unsigned SRC_LSB_POS = 0;

  typedef struct packed {
    logic split_mode_select;
    logic high_half_run;
    logic low_byte_irq_enable;
    logic capture_enable;
    logic [1:0] external_source_select;
    logic high_half_fast_clock;
    logic low_half_fast_clock;
    logic interrupt_enable;
  } control_type;

  typedef struct packed {
    logic counter_write;
    logic reload_write;
    logic clear_high_flag;
    logic clear_low_flag;
    logic [15:0] write_value;
  } write_type;

endpackage

// File: timer2_reload_capture.sv
// timer: 16-bit or dual 8-bit auto-reload counter with capture of the count
`timescale 1ns/10ps

// Function
// - split clear: one 16-bit counter, wrap loads reload word (wraps to zero in capture) and sets high flag
// - 16-bit mode: interrupt on each overflow when timer interrupts enabled
// - 16-bit mode: low byte wrap also interrupts when low interrupt enabled
// - split set: two 8-bit counters, each reloads from its own reload byte
// - split mode: run bit gates only the high byte; low byte always counts
// - per half: fast bit picks system clock, else select picks div12/rtc8/comparator
// - rtc divided source and comparator output are synchronized before use
// - split mode: high byte wrap sets high flag, low byte wrap low flag
// - split mode: interrupt on high wrap; with low enable also on low wrap
// - flags never cleared by hardware; software clears and checks both
// - low flag is set on every low byte wrap in every mode
// - capture mode is active while the capture enable bit is 1
// - capture event on comparator rising edge or every 8th rtc cycle by select msb
// - capture copies counter into reload registers and sets high flag
// - in capture the counter runs on system_clock, system_clock/12 or the other signal
module timer2_reload_capture (
  input wire logic core_clk,
  input wire logic resetn,
  input timer2_pkg::control_type ctrl,
  input timer2_pkg::write_type wr,
  input wire logic rtc_clock,
  input wire logic comparator_out,
  output logic [15:0] counter,
  output logic [15:0] reload,
  output logic high_overflow_flag,
  output logic low_overflow_flag,
  output logic timer_irq
);

  // ==========================================================
  // synchronizers and count sources
  logic [1:0] rtc_sync;
  logic [1:0] cmp_sync;
  logic rtc_prev;
  logic cmp_prev;
  logic [3:0] div12_count;
  logic [3:0] next_div12_count;
  logic [2:0] rtc_count;
  logic [2:0] next_rtc_count;
  logic div12_tick;
  logic rtc_rise;
  logic rtc8_tick;
  logic cmp_tick;

  // only the second stage is read by the edge detectors
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rtc_sync <= 2'h0;
      cmp_sync <= 2'h0;
      rtc_prev <= 1'h0;
      cmp_prev <= 1'h0;
    end else begin
      rtc_sync <= {rtc_sync[0], rtc_clock};
      cmp_sync <= {cmp_sync[0], comparator_out};
      rtc_prev <= rtc_sync[1];
      cmp_prev <= cmp_sync[1];
    end
  end

  assign rtc_rise = rtc_sync[1] & ~rtc_prev;
  assign cmp_tick = cmp_sync[1] & ~cmp_prev;
  assign div12_tick = (div12_count == 4'(timer2_pkg::SYSTEM_CLOCK_DIVIDE - 1));
  assign rtc8_tick = rtc_rise && (rtc_count == 3'(timer2_pkg::RTC_DIVIDE - 1));

  always_comb begin
    next_div12_count = div12_tick ? 4'h0 : div12_count + 4'h1;
    next_rtc_count = rtc_rise ? rtc_count + 3'h1 : rtc_count;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div12_count <= 4'h0;
      rtc_count <= 3'h0;
    end else begin
      div12_count <= next_div12_count;
      rtc_count <= next_rtc_count;
    end
  end

  // picks the count enable for one half; in capture mode the select lsb
  // chooses the signal that is not the capture source, so each can time the other
  function automatic logic source_tick(input logic fast, input logic [1:0] sel,
                                       input logic capture);
    logic t;
    t = 1'b0;
    if (fast) begin
      t = 1'b1;
    end else if (capture) begin
      if (!sel[timer2_pkg::SRC_LSB_POS]) begin
        t = div12_tick;
      end else begin
        t = sel[timer2_pkg::SRC_MSB_POS] ? rtc8_tick : cmp_tick;
      end
    end else begin
      case (sel)
        timer2_pkg::SRC_SYSTEM_CLOCK_DIV12: t = div12_tick;
        timer2_pkg::SRC_RTC_DIV8: t = rtc8_tick;
        timer2_pkg::SRC_COMPARATOR: t = cmp_tick;
        default: t = 1'b0; // reserved code stops the half
      endcase
    end
    return t;
  endfunction

  // ==========================================================
  // counter, reload, flags
  logic capture_mode;
  logic tick_low;
  logic tick_high;
  logic capture_event;
  logic low_wrap;
  logic high_wrap;
  logic [15:0] next_counter;
  logic [15:0] next_reload;
  logic next_high_flag;
  logic next_low_flag;
  logic next_irq;

  assign capture_mode = ctrl.capture_enable;
  assign tick_low = source_tick(ctrl.low_half_fast_clock, ctrl.external_source_select,
                                capture_mode);
  assign tick_high = source_tick(ctrl.high_half_fast_clock, ctrl.external_source_select,
                                 capture_mode);
  // capture source follows the select msb
  assign capture_event = capture_mode &&
    (ctrl.external_source_select[timer2_pkg::SRC_MSB_POS] ? cmp_tick : rtc8_tick);

  always_comb begin
    next_counter = counter;
    next_reload = reload;
    low_wrap = 1'b0;
    high_wrap = 1'b0;
    if (ctrl.split_mode_select) begin
      if (tick_low) begin
        low_wrap = (counter[7:0] == timer2_pkg::BYTE_ALL_ONES);
        next_counter[7:0] = low_wrap ? reload[7:0] : counter[7:0] + 8'h01;
      end
      if (tick_high && ctrl.high_half_run) begin
        high_wrap = (counter[15:8] == timer2_pkg::BYTE_ALL_ONES);
        next_counter[15:8] = high_wrap ? reload[15:8] : counter[15:8] + 8'h01;
      end
    end else if (tick_low && ctrl.high_half_run) begin
      low_wrap = (counter[7:0] == timer2_pkg::BYTE_ALL_ONES);
      high_wrap = (counter == timer2_pkg::WORD_ALL_ONES);
      if (high_wrap && !capture_mode) begin
        next_counter = reload;
      end else begin
        next_counter = counter + 16'h0001; // overflow to zero in capture
      end
    end
    if (wr.counter_write) begin
      next_counter = wr.write_value;
    end
    if (wr.reload_write) begin
      next_reload = wr.write_value;
    end
    // hardware capture beats a software reload write in the same cycle
    if (capture_event) begin
      next_reload = counter;
    end
    // set wins over a software clear; hardware never clears
    next_high_flag = (high_overflow_flag && !wr.clear_high_flag) || high_wrap ||
                     capture_event;
    next_low_flag = (low_overflow_flag && !wr.clear_low_flag) || low_wrap;
    next_irq = ctrl.interrupt_enable &&
               (next_high_flag || (ctrl.low_byte_irq_enable && next_low_flag));
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      counter <= timer2_pkg::COUNTER_RESET;
      reload <= timer2_pkg::RELOAD_RESET;
      high_overflow_flag <= 1'b0;
      low_overflow_flag <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      counter <= next_counter;
      reload <= next_reload;
      high_overflow_flag <= next_high_flag;
      low_overflow_flag <= next_low_flag;
      timer_irq <= next_irq;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  wrap16_reload_a: assert property (
    (!ctrl.split_mode_select && !capture_mode && ctrl.high_half_run && tick_low &&
     counter == 16'hffff && !wr.counter_write)
    |=> (counter == $past(reload)) && high_overflow_flag)
    else $error("16-bit wrap did not reload or set high flag");

  high_irq_a: assert property (
    (ctrl.interrupt_enable && high_wrap) |=> timer_irq)
    else $error("overflow with interrupts enabled gave no request");

  low_irq_a: assert property (
    (ctrl.interrupt_enable && ctrl.low_byte_irq_enable && low_wrap) |=> timer_irq)
    else $error("low byte wrap with low enable gave no request");

  no_low_irq_a: assert property (
    (!high_overflow_flag && !ctrl.low_byte_irq_enable && low_overflow_flag &&
     !high_wrap && !capture_event) |=> !timer_irq)
    else $error("low flag alone raised a request without low enable");

  split_low_free_a: assert property (
    (ctrl.split_mode_select && !ctrl.high_half_run && tick_low &&
     counter[7:0] == 8'hff && !wr.counter_write)
    |=> counter[7:0] == $past(reload[7:0]) && low_overflow_flag &&
        counter[15:8] == $past(counter[15:8]))
    else $error("split low byte did not reload or high byte moved");

  flag_sticky_a: assert property (
    high_overflow_flag && !wr.clear_high_flag |=> high_overflow_flag)
    else $error("high flag dropped without a clear");

  capture_copy_a: assert property (
    capture_event |=> reload == $past(counter) && high_overflow_flag)
    else $error("capture did not copy count or set flag");

  capture_no_reload_a: assert property (
    (capture_mode && !ctrl.split_mode_select && ctrl.high_half_run && tick_low &&
     counter == 16'hffff && !wr.counter_write) |=> counter == 16'h0000)
    else $error("counter reloaded during capture");

  div12_rate_a: assert property (
    div12_tick |=> !div12_tick [*8] ##4 div12_tick)
    else $error("system clock divider period is not twelve");

  cmp_sync_a: assert property (
    $rose(comparator_out) ##1 comparator_out |=> cmp_tick)
    else $error("comparator edge not seen after synchronizer");

  wrap16_c: cover property (high_wrap && !ctrl.split_mode_select);
  split_both_c: cover property (ctrl.split_mode_select && low_wrap ##[1:300] high_wrap);
  capture_c: cover property (capture_event ##[1:1000] capture_event);

endmodule // timer2_reload_capture

// File: test_timer2_reload_capture.sv
// testbench: self-checking sequences for the reload/capture timer
`timescale 1ns/10ps
module test_timer2_reload_capture;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  timer2_pkg::control_type ctrl = '0;
  timer2_pkg::write_type wr = '0;
  logic rtc_clock = 1'b0;
  logic comparator_out = 1'b0;
  logic [15:0] counter;
  logic [15:0] reload;
  logic high_overflow_flag;
  logic low_overflow_flag;
  logic timer_irq;
  logic [15:0] r1;
  logic [15:0] r2;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  bit rtc_run = 1'b0;
  bit comp_run = 1'b0;
  timer2_reload_capture timer2_reload_capture_i (
    .core_clk(core_clk),
    .resetn(resetn),
    .ctrl(ctrl),
    .wr(wr),
    .rtc_clock(rtc_clock),
    .comparator_out(comparator_out),
    .counter(counter),
    .reload(reload),
    .high_overflow_flag(high_overflow_flag),
    .low_overflow_flag(low_overflow_flag),
    .timer_irq(timer_irq)
  );
  always #50 core_clk = ~core_clk;
  // ==========================================================
  // outside sources: rtc period 4 cycles, comparator period 20 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (rtc_run && cycles[0]) rtc_clock <= #1 ~rtc_clock;
    if (comp_run && cycles % 10 == 0) comparator_out <= #1 ~comparator_out;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
  // ==========================================================
  // access tasks
  function automatic logic [15:0] flags();
    return {13'h0, high_overflow_flag, low_overflow_flag, timer_irq};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic write_reg(input logic to_reload, input logic [15:0] v);
    wr.reload_write = to_reload;
    wr.counter_write = ~to_reload;
    wr.write_value = v;
    step(1);
    wr.reload_write = 1'b0;
    wr.counter_write = 1'b0;
  endtask
  task automatic clear_flags();
    wr.clear_high_flag = 1'b1;
    wr.clear_low_flag = 1'b1;
    step(1);
    wr.clear_high_flag = 1'b0;
    wr.clear_low_flag = 1'b0;
  endtask
  // counts ticks over whole periods, so the divider phase does not matter
  task automatic count_over(input logic [1:0] sel, input int n, input logic [15:0] want);
    ctrl.external_source_select = sel;
    step(40);
    r1 = counter;
    step(n);
    check(counter - r1, want);
  endtask
  task automatic wait_capture(output logic [15:0] got);
    for (int i = 0; i < 60 && high_overflow_flag !== 1'b1; i++) step(1);
    got = reload;
    check(counter - reload, 16'h1);
    clear_flags();
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // test sequence
  initial begin
    step(20);
    resetn = 1'b1;
    step(1);
    check(counter | reload | flags(), 16'h0);
    $display("test reset done");
    ctrl.interrupt_enable = 1'b1;
    write_reg(1'b1, 16'h1234);
    step(1);
    write_reg(1'b0, 16'hfffe);
    ctrl.low_half_fast_clock = 1'b1;
    ctrl.high_half_run = 1'b1;
    step(1);
    check(counter, 16'hffff);
    step(1);
    check(counter, 16'h1234);
    check(flags(), 16'h7);
    ctrl.high_half_run = 1'b0;
    step(5);
    check(flags(), 16'h7);
    clear_flags();
    write_reg(1'b0, 16'h12ff);
    ctrl.high_half_run = 1'b1;
    step(1);
    check(flags(), 16'h2);
    ctrl.low_byte_irq_enable = 1'b1;
    step(1);
    check(flags(), 16'h3);
    $display("test sixteen bit done");
    ctrl = '0;
    ctrl.interrupt_enable = 1'b1;
    ctrl.split_mode_select = 1'b1;
    ctrl.low_half_fast_clock = 1'b1;
    ctrl.high_half_fast_clock = 1'b1;
    clear_flags();
    write_reg(1'b1, 16'h8010);
    step(1);
    write_reg(1'b0, 16'h20fe);
    step(2);
    check(counter, 16'h2010);
    check(flags(), 16'h2);
    clear_flags();
    ctrl.high_half_run = 1'b1;
    write_reg(1'b0, 16'hff50);
    step(1);
    check(counter, 16'h8051);
    check(flags(), 16'h5);
    $display("test split done");
    ctrl = '0;
    ctrl.high_half_run = 1'b1;
    rtc_run = 1'b1;
    comp_run = 1'b1;
    count_over(2'h0, 36, 16'h3);
    count_over(2'h2, 36, 16'h0);
    count_over(2'h1, 64, 16'h2);
    count_over(2'h3, 40, 16'h2);
    ctrl.low_half_fast_clock = 1'b1;
    count_over(2'h2, 36, 16'h24);
    $display("test sources done");
    ctrl.external_source_select = 2'h3;
    clear_flags();
    step(45);
    check(reload, 16'h8010);
    check({15'h0, high_overflow_flag}, 16'h0);
    ctrl.capture_enable = 1'b1; // split stays clear while capturing
    wait_capture(r1);
    wait_capture(r1);
    wait_capture(r2);
    check(r2 - r1, 16'h14);
    ctrl.external_source_select = 2'h0;
    wait_capture(r1);
    wait_capture(r1);
    wait_capture(r2);
    check(r2 - r1, 16'h20);
    write_reg(1'b0, 16'hfffe);
    step(2);
    check(counter, 16'h0000);
    $display("test capture done");
    final_report();
  end
endmodule // test_timer2_reload_capture
